// ### src/fpshp_port.sv
// host data port: sync fifo, async fifo and serial link slave modes
// Function
// - sync mode: read or write, never both
// - sync transfers on interface clock rise
// - sync mode drives continuous interface clock
// - sync only when stored mode is async
// - receive-available low means read may start
// - first byte on bus once enable low
// - burst or wait; advance after strobe sampled
// - receive-available high when buffer drained
// - write accepted when space and strobe low
// - async: transfer on strobe falling edge
// - async: no clock out, enable ignored
// - serial half-duplex slave, 1/2/4/8 lines
// - idle: write status line0, read status out
// - idle status output can be switched off
// - command phase, then data with ACK/NAK
// - width and command on first edge, 8 lines
// - priority width decode 8, 4, 2, 1
// - unused lines pulled up, read as one
// - command bits at 0,3,5,6; width 1,2,4
`timescale 1ns/1ps
`default_nettype none

module fpshp_port
	import fpshp_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// configuration levels
	input wire logic stored_link_sel,
	input wire logic sync_mode_cmd,
	input wire logic status_enable,
	output logic [1:0] active_mode,
	// usb engine, towards host port
	input wire logic usb_rx_valid,
	output logic usb_rx_ready,
	input wire logic [DATA_W-1:0] usb_rx_data,
	// usb engine, from host port
	output logic usb_tx_valid,
	input wire logic usb_tx_ready,
	output logic [DATA_W-1:0] usb_tx_data,
	// parallel fifo pins
	output logic interface_clock_out,
	output logic rx_data_available_n,
	output logic tx_space_available_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic oe_n,
	input wire logic [DATA_W-1:0] fifo_data_in,
	output logic [DATA_W-1:0] fifo_data_out,
	output logic fifo_data_oe_n,
	// serial link pins
	input wire logic ss_n,
	input wire logic link_clk,
	input wire logic [DATA_W-1:0] bidir_data_lines_in,
	output logic [DATA_W-1:0] bidir_data_lines_out,
	output logic [DATA_W-1:0] bidir_data_lines_oe_n,
	output logic miso_out,
	output logic miso_oe_n
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic fpshp_width_t decode_width(input logic [DATA_W-1:0] l);
		if (!(&l[7:4])) begin
			return WIDTH_8;
		end else if (!(&l[3:2])) begin
			return WIDTH_4;
		end else if (!l[1]) begin
			return WIDTH_2;
		end else begin
			return WIDTH_1;
		end
	endfunction : decode_width

	function automatic logic [3:0] width_bits(input fpshp_width_t w);
		case (w)
			WIDTH_2: return 4'h2;
			WIDTH_4: return 4'h4;
			WIDTH_8: return 4'h8;
			default: return 4'h1;
		endcase
	endfunction : width_bits

	function automatic logic [DATA_W-1:0] lane_mask(input fpshp_width_t w);
		case (w)
			WIDTH_2: return 8'h03;
			WIDTH_4: return 8'h0f;
			WIDTH_8: return 8'hff;
			default: return 8'h01;
		endcase
	endfunction : lane_mask

	// lsb first: new lanes enter at the top
	function automatic logic [DATA_W-1:0] shift_in(input logic [DATA_W-1:0] sh,
		input logic [DATA_W-1:0] l, input fpshp_width_t w);
		case (w)
			WIDTH_2: return {l[1:0], sh[7:2]};
			WIDTH_4: return {l[3:0], sh[7:4]};
			WIDTH_8: return l;
			default: return {l[0], sh[7:1]};
		endcase
	endfunction : shift_in

	// ----------------------------------------------------------------
	// pin synchroniser
	// ----------------------------------------------------------------
	logic [PIN_W-1:0] s1_reg;
	logic [PIN_W-1:0] s2_reg;
	logic [PIN_W-1:0] s3_reg;
	logic [PIN_W-1:0] filt_reg;
	logic [PIN_W-1:0] prev_reg;

	wire [PIN_W-1:0] pins = {ss_n, link_clk, rd_n, wr_n, oe_n, fifo_data_in, bidir_data_lines_in};
	wire [PIN_W-1:0] agree = ~(s2_reg ^ s3_reg);
	wire [PIN_W-1:0] filt_next = (agree & s2_reg) | (~agree & filt_reg);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s1_reg <= '1;
			s2_reg <= '1;
			s3_reg <= '1;
			filt_reg <= '1;
			prev_reg <= '1;
		end else begin
			s1_reg <= pins;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			filt_reg <= filt_next;
			prev_reg <= filt_reg;
		end
	end

	wire f_ss_n = filt_reg[PIN_SS];
	wire f_rd_n = filt_reg[PIN_RD];
	wire f_wr_n = filt_reg[PIN_WR];
	wire f_oe_n = filt_reg[PIN_OE];
	wire [DATA_W-1:0] f_fdata = filt_reg[PIN_FDATA_LSB +: DATA_W];
	wire [DATA_W-1:0] f_lines = filt_reg[PIN_LINES_LSB +: DATA_W];
	wire rd_fall = prev_reg[PIN_RD] && !f_rd_n;
	wire wr_fall = prev_reg[PIN_WR] && !f_wr_n;
	wire lclk_rise = !prev_reg[PIN_LCLK] && filt_reg[PIN_LCLK];

	// ----------------------------------------------------------------
	// mode select
	// ----------------------------------------------------------------
	fpshp_mode_t mode_reg;
	fpshp_mode_t mode_next;

	assign mode_next = stored_link_sel ? MODE_LINK :
		(sync_mode_cmd ? MODE_SYNC : MODE_ASYNC);
	wire is_sync = (mode_reg == MODE_SYNC);
	wire is_async = (mode_reg == MODE_ASYNC);
	wire is_link = (mode_reg == MODE_LINK);
	assign active_mode = mode_reg;

	// ----------------------------------------------------------------
	// buffers
	// ----------------------------------------------------------------
	logic rx_valid;
	logic [DATA_W-1:0] rx_head;
	logic [FIFO_LVL_W-1:0] rx_level;
	logic tx_ready;
	logic [FIFO_LVL_W-1:0] tx_level;
	logic rx_pop;
	logic tx_push;
	logic [DATA_W-1:0] tx_byte;
	logic link_rx_pop;
	logic link_tx_push;

	fpshp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) rx_fifo (
		.clock(clock),
		.rst(rst),
		.in_valid(usb_rx_valid),
		.in_ready(usb_rx_ready),
		.in_data(usb_rx_data),
		.out_valid(rx_valid),
		.out_ready(rx_pop),
		.out_data(rx_head),
		.level(rx_level)
	);

	fpshp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
		.clock(clock),
		.rst(rst),
		.in_valid(tx_push),
		.in_ready(tx_ready),
		.in_data(tx_byte),
		.out_valid(usb_tx_valid),
		.out_ready(usb_tx_ready),
		.out_data(usb_tx_data),
		.level(tx_level)
	);

	// ----------------------------------------------------------------
	// parallel fifo modes
	// ----------------------------------------------------------------
	logic [IFCLK_CNT_W-1:0] ifclk_cnt_reg;
	logic ifclk_reg;
	logic rxf_reg;
	logic txe_reg;
	logic [DATA_W-1:0] fdata_out_reg;
	logic fdata_oe_n_reg;

	wire if_rise = is_sync && (ifclk_cnt_reg == IFCLK_RISE_CNT);
	wire ifclk_next = is_sync && (if_rise || (ifclk_reg && ifclk_cnt_reg != IFCLK_FALL_CNT));
	wire [IFCLK_CNT_W-1:0] ifclk_cnt_next = (!is_sync || ifclk_cnt_reg == IFCLK_FALL_CNT) ?
		IFCLK_CNT_ZERO : ifclk_cnt_reg + IFCLK_CNT_ONE;

	// a read needs the bus turned first; a turned bus blocks writes
	wire sync_rd_take = if_rise && !f_oe_n && !f_rd_n && !rxf_reg && rx_valid;
	wire sync_wr_take = if_rise && f_oe_n && !f_wr_n && !txe_reg && tx_ready;
	wire async_rd_take = is_async && rd_fall && rx_valid;
	wire async_wr_take = is_async && wr_fall && tx_ready;
	wire flag_update = if_rise || is_async;

	// flags look past the byte taken on this edge so no stale byte is offered
	wire rxf_next = (rx_level == LVL_EMPTY) ||
		((rx_level == LVL_ONE) && (sync_rd_take || async_rd_take));
	wire txe_next = (tx_level == LVL_FULL) ||
		((tx_level == LVL_ALMOST_FULL) && (sync_wr_take || async_wr_take));
	wire fdata_load = is_sync || (is_async && f_rd_n);
	wire fdata_drive = (is_sync && !f_oe_n) || (is_async && !f_rd_n);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mode_reg <= MODE_ASYNC;
			ifclk_cnt_reg <= IFCLK_CNT_ZERO;
			ifclk_reg <= 1'b0;
			rxf_reg <= 1'b1;
			txe_reg <= 1'b1;
			fdata_out_reg <= BYTE_ZERO;
			fdata_oe_n_reg <= 1'b1;
		end else begin
			mode_reg <= mode_next;
			ifclk_cnt_reg <= ifclk_cnt_next;
			ifclk_reg <= ifclk_next;
			rxf_reg <= is_link ? 1'b1 : (flag_update ? rxf_next : rxf_reg);
			txe_reg <= is_link ? 1'b1 : (flag_update ? txe_next : txe_reg);
			fdata_out_reg <= fdata_load ? rx_head : fdata_out_reg;
			fdata_oe_n_reg <= !fdata_drive;
		end
	end

	assign interface_clock_out = ifclk_reg;
	assign rx_data_available_n = rxf_reg;
	assign tx_space_available_n = txe_reg;
	assign fifo_data_out = fdata_out_reg;
	assign fifo_data_oe_n = fdata_oe_n_reg;

	// ----------------------------------------------------------------
	// serial link slave
	// ----------------------------------------------------------------
	fpshp_link_t lstate_reg;
	fpshp_link_t lstate_next;
	logic [3:0] cmd_reg;
	logic [3:0] cmd_next;
	fpshp_width_t wsel_reg;
	fpshp_width_t wsel_next;
	logic [DATA_W-1:0] sh_reg;
	logic [DATA_W-1:0] sh_next;
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic nak_reg;
	logic nak_next;
	logic [DATA_W-1:0] lines_out_reg;
	logic [DATA_W-1:0] lines_oe_n_reg;
	logic miso_reg;
	logic miso_oe_n_reg;

	wire ss_act = is_link && !f_ss_n;
	wire [3:0] cmd_rx = {f_lines[CMD_B3], f_lines[CMD_B2], f_lines[CMD_B1], f_lines[CMD_B0]};
	wire [3:0] cnt_sum = cnt_reg + width_bits(wsel_reg);
	wire byte_done = (cnt_sum == BITS_PER_BYTE);
	wire [DATA_W-1:0] sh_in = shift_in(sh_reg, f_lines, wsel_reg);
	wire [DATA_W-1:0] sh_out = sh_reg >> width_bits(wsel_reg);
	wire rd_cmd = (cmd_reg == LINK_CMD_READ);
	wire wr_cmd = (cmd_reg == LINK_CMD_WRITE);

	always_comb begin
		lstate_next = lstate_reg;
		cmd_next = cmd_reg;
		wsel_next = wsel_reg;
		sh_next = sh_reg;
		cnt_next = cnt_reg;
		nak_next = nak_reg;
		link_rx_pop = 1'b0;
		link_tx_push = 1'b0;
		case (lstate_reg)
			LINK_IDLE: begin
				nak_next = LINK_NAK;
				if (ss_act) begin
					lstate_next = LINK_CMD;
					cnt_next = BIT_CNT_ZERO;
				end
			end
			LINK_CMD: begin
				if (!ss_act) begin
					lstate_next = LINK_IDLE;
				end else if (lclk_rise) begin
					lstate_next = LINK_DATA;
					cmd_next = cmd_rx;
					wsel_next = decode_width(f_lines);
					cnt_next = BIT_CNT_ZERO;
					if (cmd_rx == LINK_CMD_READ) begin
						sh_next = rx_head;
						link_rx_pop = rx_valid;
						nak_next = !rx_valid;
					end else begin
						nak_next = !((cmd_rx == LINK_CMD_WRITE) && tx_ready);
					end
				end
			end
			LINK_DATA: begin
				if (!ss_act) begin
					lstate_next = LINK_IDLE;
				end else if (lclk_rise) begin
					cnt_next = byte_done ? BIT_CNT_ZERO : cnt_sum;
					if (wr_cmd) begin
						sh_next = sh_in;
						link_tx_push = byte_done && tx_ready;
						nak_next = !tx_ready;
					end else if (rd_cmd) begin
						sh_next = sh_out;
						if (byte_done) begin
							sh_next = rx_head;
							link_rx_pop = rx_valid;
							nak_next = !rx_valid;
						end
					end
				end
			end
			default: begin
				lstate_next = LINK_IDLE;
			end
		endcase
	end

	// idle status shares line 0 and the slave output with other slaves
	wire idle_drive = (lstate_next == LINK_IDLE) && is_link && status_enable;
	wire rd_drive = (lstate_next == LINK_DATA) && (cmd_next == LINK_CMD_READ) && !nak_next;
	wire [DATA_W-1:0] lines_out_next = idle_drive ? {7'h00, !tx_ready} : sh_next;
	wire [DATA_W-1:0] lines_oe_n_next = rd_drive ? ~lane_mask(wsel_next) :
		(idle_drive ? ~8'h01 : ALL_OFF);
	wire miso_next = idle_drive ? !rx_valid : nak_next;
	wire miso_oe_n_next = !(idle_drive || (lstate_next != LINK_IDLE && ss_act));

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lstate_reg <= LINK_IDLE;
			cmd_reg <= LINK_CMD_WRITE;
			wsel_reg <= WIDTH_1;
			sh_reg <= BYTE_ZERO;
			cnt_reg <= BIT_CNT_ZERO;
			nak_reg <= LINK_NAK;
			lines_out_reg <= BYTE_ZERO;
			lines_oe_n_reg <= ALL_OFF;
			miso_reg <= LINK_NAK;
			miso_oe_n_reg <= 1'b1;
		end else begin
			lstate_reg <= lstate_next;
			cmd_reg <= cmd_next;
			wsel_reg <= wsel_next;
			sh_reg <= sh_next;
			cnt_reg <= cnt_next;
			nak_reg <= nak_next;
			lines_out_reg <= lines_out_next;
			lines_oe_n_reg <= lines_oe_n_next;
			miso_reg <= miso_next;
			miso_oe_n_reg <= miso_oe_n_next;
		end
	end

	assign bidir_data_lines_out = lines_out_reg;
	assign bidir_data_lines_oe_n = lines_oe_n_reg;
	assign miso_out = miso_reg;
	assign miso_oe_n = miso_oe_n_reg;

	// ----------------------------------------------------------------
	// buffer access merge
	// ----------------------------------------------------------------
	assign rx_pop = sync_rd_take || async_rd_take || link_rx_pop;
	assign tx_push = sync_wr_take || async_wr_take || link_tx_push;
	assign tx_byte = is_link ? sh_in : f_fdata;

endmodule : fpshp_port

`default_nettype wire

// ### pkg/fpshp_pkg.sv
// shared constants and types for the fifo parallel / serial host port
package fpshp_pkg;

	// ----------------------------------------------------------------
	// data path
	// ----------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_LVL_W = $clog2(FIFO_DEPTH) + 1;
	localparam logic [FIFO_LVL_W-1:0] LVL_EMPTY = 4'h0;
	localparam logic [FIFO_LVL_W-1:0] LVL_ONE = 4'h1;
	localparam logic [FIFO_LVL_W-1:0] LVL_FULL = 4'h8;
	localparam logic [FIFO_LVL_W-1:0] LVL_ALMOST_FULL = 4'h7;

	// ----------------------------------------------------------------
	// clocks
	// ----------------------------------------------------------------
	localparam int SYS_CLK_MHZ = 25;
	localparam int IFCLK_NOM_MHZ = 60;
	localparam int SYNC_STAGES = 3;
	// half period of the interface clock, at least one cycle and long enough
	// for a pin change to clear the input synchroniser before the next edge
	localparam int IFCLK_HALF_RAW = (SYS_CLK_MHZ + 2 * IFCLK_NOM_MHZ - 1) / (2 * IFCLK_NOM_MHZ);
	localparam int IFCLK_HALF_CYC = (IFCLK_HALF_RAW > SYNC_STAGES + 1) ?
		IFCLK_HALF_RAW : SYNC_STAGES + 1;
	localparam int IFCLK_CNT_W = $clog2(2 * IFCLK_HALF_CYC);
	localparam logic [IFCLK_CNT_W-1:0] IFCLK_RISE_CNT = IFCLK_CNT_W'(IFCLK_HALF_CYC - 1);
	localparam logic [IFCLK_CNT_W-1:0] IFCLK_FALL_CNT = IFCLK_CNT_W'(2 * IFCLK_HALF_CYC - 1);
	localparam logic [IFCLK_CNT_W-1:0] IFCLK_CNT_ZERO = 3'h0;
	localparam logic [IFCLK_CNT_W-1:0] IFCLK_CNT_ONE = 3'h1;

	// ----------------------------------------------------------------
	// sampled pin vector layout
	// ----------------------------------------------------------------
	localparam int PIN_LINES_LSB = 0;
	localparam int PIN_FDATA_LSB = 8;
	localparam int PIN_OE = 16;
	localparam int PIN_WR = 17;
	localparam int PIN_RD = 18;
	localparam int PIN_LCLK = 19;
	localparam int PIN_SS = 20;
	localparam int PIN_W = 21;

	// ----------------------------------------------------------------
	// serial link command byte and widths
	// ----------------------------------------------------------------
	localparam int CMD_B3 = 0;
	localparam int CMD_B2 = 3;
	localparam int CMD_B1 = 5;
	localparam int CMD_B0 = 6;
	// codes reachable at every width: unused lines read as one
	localparam logic [3:0] LINK_CMD_WRITE = 4'h7;
	localparam logic [3:0] LINK_CMD_READ = 4'hf;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
	localparam logic LINK_ACK = 1'b0;
	localparam logic LINK_NAK = 1'b1;
	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [DATA_W-1:0] ALL_OFF = 8'hff;

	typedef enum logic [1:0] {
		WIDTH_1,
		WIDTH_2,
		WIDTH_4,
		WIDTH_8
	} fpshp_width_t;

	typedef enum logic [1:0] {
		MODE_ASYNC,
		MODE_SYNC,
		MODE_LINK
	} fpshp_mode_t;

	typedef enum logic [1:0] {
		LINK_IDLE,
		LINK_CMD,
		LINK_DATA
	} fpshp_link_t;

endpackage : fpshp_pkg

// ### src/fpshp_fifo.sv
// small first-word-fall-through fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module fpshp_fifo
	import fpshp_pkg::*;
#(
	parameter int WIDTH = DATA_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	// occupancy
	output logic [$clog2(DEPTH):0] level
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wptr_reg;
	logic [AW:0] rptr_reg;

	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	wire full = (wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
	wire empty = (wptr_reg == rptr_reg);

	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rptr_reg[AW-1:0]];
	assign level = wptr_reg - rptr_reg;

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wptr_reg[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
		end else begin
			wptr_reg <= wptr_reg + (AW+1)'(push);
			rptr_reg <= rptr_reg + (AW+1)'(pop);
		end
	end

endmodule : fpshp_fifo

`default_nettype wire

// ### tb/fpshp_port_chk.sv
// concurrent checks on the host port pins
`timescale 1ns/1ps
`default_nettype none

module fpshp_port_chk
	import fpshp_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// watched ports
	input wire logic [1:0] active_mode,
	input wire logic usb_rx_ready,
	input wire logic usb_tx_valid,
	input wire logic interface_clock_out,
	input wire logic tx_space_available_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic oe_n,
	input wire logic fifo_data_oe_n,
	input wire logic ss_n,
	input wire logic status_enable,
	input wire logic [DATA_W-1:0] bidir_data_lines_oe_n,
	input wire logic miso_oe_n
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	logic sy;
	logic lk;
	assign sy = active_mode == MODE_SYNC;
	assign lk = active_mode == MODE_LINK;

	no_async_clk_a: assert property (active_mode == MODE_ASYNC |-> !interface_clock_out)
		else $error("interface clock runs in async mode");
	clk_shape_a: assert property (sy && $rose(interface_clock_out) |->
		interface_clock_out[*4] ##1 !interface_clock_out[*4] ##1 interface_clock_out)
		else $error("interface clock shape wrong");
	bus_release_a: assert property ((sy && oe_n)[*6] |-> fifo_data_oe_n)
		else $error("bus driven while enable high");
	one_dir_a: assert property (sy && $rose(usb_tx_valid) |-> fifo_data_oe_n)
		else $error("write taken while bus driven");
	wr_accept_a: assert property (sy && $rose(usb_tx_valid) |->
		!$past(wr_n, 2) && !$past(tx_space_available_n, 2))
		else $error("write taken without strobe and space");
	async_rd_a: assert property (active_mode == MODE_ASYNC && $fell(fifo_data_oe_n) |->
		!rd_n && !$past(rd_n, 3))
		else $error("async read without strobe edge");
	idle_status_a: assert property ((lk && ss_n && status_enable)[*8] |->
		!miso_oe_n && bidir_data_lines_oe_n == 8'hfe)
		else $error("idle status not shown");
	status_off_a: assert property ((lk && ss_n && !status_enable)[*8] |->
		miso_oe_n && &bidir_data_lines_oe_n)
		else $error("idle status driven while off");
	frame_miso_a: assert property ((lk && !ss_n)[*6] |-> !miso_oe_n)
		else $error("ack line not driven in frame");

	cover property (sy && $fell(fifo_data_oe_n));
	cover property (lk && !ss_n && !miso_oe_n);
	cover property (!usb_rx_ready);
endmodule : fpshp_port_chk

bind fpshp_port fpshp_port_chk fpshp_port_chk_inst (.clock, .rst, .active_mode, .usb_rx_ready,
	.usb_tx_valid, .interface_clock_out, .tx_space_available_n, .rd_n, .wr_n, .oe_n,
	.fifo_data_oe_n, .ss_n, .status_enable, .bidir_data_lines_oe_n, .miso_oe_n);

`default_nettype wire

// ### tb/fpshp_link_master.sv
// serial link master on the far side of the port
`timescale 1ns/1ps
`default_nettype none

module fpshp_link_master (
	// pacing clock
	input wire logic clock,
	// link pins
	output logic ss_n,
	output logic link_clk,
	output logic [7:0] lines_to_dev,
	input wire logic [7:0] dev_lines_out,
	input wire logic [7:0] dev_lines_oe_n,
	input wire logic miso_out,
	input wire logic miso_oe_n
);
	logic [7:0] m_out = 8'hff;
	logic m_drv = 1'b0;
	// ack state seen at the latest link clock rise
	logic last_st = 1'b1;
	// undriven lines float up
	assign lines_to_dev = (~dev_lines_oe_n & dev_lines_out) | (dev_lines_oe_n & (m_drv ? m_out : 8'hff));
	initial begin
		ss_n = 1'b1;
		link_clk = 1'b0;
	end

	task automatic start();
		ss_n = 1'b0;
		repeat (4) @(negedge clock);
	endtask : start

	// one link clock; lines released in the high phase
	task automatic edge_step(input logic [7:0] d, input logic drv, output logic [7:0] got);
		m_out = d;
		m_drv = drv;
		repeat (4) @(negedge clock);
		link_clk = 1'b1;
		got = lines_to_dev;
		last_st = miso_oe_n ? 1'b1 : miso_out;
		repeat (2) @(negedge clock);
		m_drv = 1'b0;
		repeat (2) @(negedge clock);
		link_clk = 1'b0;
	endtask : edge_step

	task automatic stop(output logic ack);
		repeat (2) @(negedge clock);
		ack = miso_oe_n ? 1'b1 : miso_out;
		ss_n = 1'b1;
		repeat (8) @(negedge clock);
	endtask : stop
endmodule : fpshp_link_master

`default_nettype wire

// ### tb/tb_fifo_parallel_serial_host_port.sv
// self-checking bench for the host port
`timescale 1ns/1ps
`default_nettype none

module tb_fifo_parallel_serial_host_port import fpshp_pkg::*;;
	logic clock = 1'b0;
	logic rst;
	logic stored_link_sel = 1'b0;
	logic sync_mode_cmd = 1'b0;
	logic status_enable = 1'b0;
	logic usb_rx_valid = 1'b0;
	logic usb_tx_ready = 1'b1;
	logic rd_n = 1'b1;
	logic wr_n = 1'b1;
	logic oe_n = 1'b1;
	logic [7:0] usb_rx_data = 8'h00;
	logic [7:0] fifo_data_in = 8'h00;
	logic [1:0] active_mode;
	logic usb_rx_ready, usb_tx_valid, interface_clock_out, rx_data_available_n;
	logic tx_space_available_n, fifo_data_oe_n, ss_n, link_clk, miso_out, miso_oe_n, ack;
	logic [7:0] usb_tx_data, fifo_data_out, bidir_data_lines_in, bidir_data_lines_out;
	logic [7:0] bidir_data_lines_oe_n, got;
	logic [7:0] txq[$];
	int num_errors = 0;
	int samples_checked = 0;

	always #20 clock = ~clock;

	fpshp_port fpshp_port_inst (.clock, .rst, .stored_link_sel, .sync_mode_cmd, .status_enable,
		.active_mode, .usb_rx_valid, .usb_rx_ready, .usb_rx_data, .usb_tx_valid, .usb_tx_ready,
		.usb_tx_data, .interface_clock_out, .rx_data_available_n, .tx_space_available_n, .rd_n,
		.wr_n, .oe_n, .fifo_data_in, .fifo_data_out, .fifo_data_oe_n, .ss_n, .link_clk,
		.bidir_data_lines_in, .bidir_data_lines_out, .bidir_data_lines_oe_n, .miso_out, .miso_oe_n);

	fpshp_link_master fpshp_link_master_inst (.clock, .ss_n, .link_clk,
		.lines_to_dev(bidir_data_lines_in), .dev_lines_out(bidir_data_lines_out),
		.dev_lines_oe_n(bidir_data_lines_oe_n), .miso_out, .miso_oe_n);

	always @(posedge clock) begin
		if (usb_tx_valid === 1'b1 && usb_tx_ready === 1'b1) begin
			txq.push_back(usb_tx_data);
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [7:0] got_v, input logic [7:0] exp_v);
		samples_checked++;
		if (got_v !== exp_v) begin
			num_errors++;
			$display("BAD %0t got %h expected %h", $time, got_v, exp_v);
		end
	endtask : check

	task automatic summarize();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize

	task automatic do_reset();
		rst = 1'b1;
		repeat (3) @(negedge clock);
		rst = 1'b0;
		repeat (6) @(negedge clock);
	endtask : do_reset

	task automatic push(input logic [7:0] d);
		usb_rx_valid = 1'b1;
		usb_rx_data = d;
		while (usb_rx_ready !== 1'b1) @(negedge clock);
		@(negedge clock);
	endtask : push

	task automatic at_rise();
		@(posedge interface_clock_out);
		@(negedge clock);
	endtask : at_rise

	task automatic async_read(input logic [7:0] exp_v);
		rd_n = 1'b0;
		repeat (6) @(negedge clock);
		check(fifo_data_out, exp_v);
		rd_n = 1'b1;
		repeat (6) @(negedge clock);
	endtask : async_read

	task automatic expect_tx(input logic [7:0] exp_v);
		for (int k = 0; k < 40 && txq.size() == 0; k++)
			@(negedge clock);
		if (txq.size() == 0) begin
			num_errors++;
			$display("BAD %0t no byte reached the usb side", $time);
		end else begin
			check(txq.pop_front(), exp_v);
		end
	endtask : expect_tx

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_async();
		oe_n = 1'b0;
		do_reset();
		check(8'(active_mode), 8'(MODE_ASYNC));
		for (int i = 0; i < 8; i++)
			push(8'(8'ha0 + i));
		usb_rx_valid = 1'b0;
		@(negedge clock);
		check(8'(usb_rx_ready), 8'h00);
		for (int i = 0; i < 8; i++)
			async_read(8'(8'ha0 + i));
		check(8'(rx_data_available_n), 8'h01);
		fifo_data_in = 8'hc3;
		wr_n = 1'b0;
		repeat (6) @(negedge clock);
		wr_n = 1'b1;
		oe_n = 1'b1;
		expect_tx(8'hc3);
	endtask : t_async

	task automatic t_sync();
		sync_mode_cmd = 1'b1;
		do_reset();
		check(8'(active_mode), 8'(MODE_SYNC));
		for (int i = 1; i < 4; i++)
			push(8'(8'h11 * i));
		usb_rx_valid = 1'b0;
		at_rise();
		at_rise();
		check(8'(rx_data_available_n), 8'h00);
		oe_n = 1'b0;
		at_rise();
		rd_n = 1'b0;
		for (int i = 1; i < 4; i++) begin
			repeat (3) @(negedge clock);
			check(8'(fifo_data_oe_n), 8'h00);
			check(fifo_data_out, 8'(8'h11 * i));
			at_rise();
		end
		repeat (3) @(negedge clock);
		check(8'(rx_data_available_n), 8'h01);
		rd_n = 1'b1;
		check(8'(tx_space_available_n), 8'h00);
		fifo_data_in = 8'h77;
		wr_n = 1'b0;
		at_rise();
		at_rise();
		oe_n = 1'b1;
		fifo_data_in = 8'h5a;
		at_rise();
		fifo_data_in = 8'ha5;
		at_rise();
		wr_n = 1'b1;
		expect_tx(8'h5a);
		expect_tx(8'ha5);
	endtask : t_sync

	task automatic t_link();
		stored_link_sel = 1'b1;
		status_enable = 1'b1;
		do_reset();
		check(8'(active_mode), 8'(MODE_LINK));
		repeat (12) @(negedge clock);
		fpshp_link_master_inst.start();
		fpshp_link_master_inst.edge_step(8'h68, 1'b1, got);
		fpshp_link_master_inst.edge_step(8'h96, 1'b1, got);
		fpshp_link_master_inst.stop(ack);
		check(8'(ack), 8'(LINK_ACK));
		expect_tx(8'h96);
		// 1-bit write: upper lines left high, line 0 lsb first
		fpshp_link_master_inst.start();
		fpshp_link_master_inst.edge_step(8'hfe, 1'b1, got);
		for (int i = 0; i < 8; i++)
			fpshp_link_master_inst.edge_step(8'hfe | ((8'h5c >> i) & 8'h01), 1'b1, got);
		fpshp_link_master_inst.stop(ack);
		check(8'(ack), 8'(LINK_ACK));
		expect_tx(8'h5c);
		push(8'h3c);
		usb_rx_valid = 1'b0;
		fpshp_link_master_inst.start();
		fpshp_link_master_inst.edge_step(8'h69, 1'b1, got);
		fpshp_link_master_inst.edge_step(8'hff, 1'b0, got);
		fpshp_link_master_inst.stop(ack);
		check(got, 8'h3c);
		check(8'(fpshp_link_master_inst.last_st), 8'(LINK_ACK));
		// buffer drained by that byte, so the next one is refused
		check(8'(ack), 8'(LINK_NAK));
		fpshp_link_master_inst.start();
		fpshp_link_master_inst.edge_step(8'h20, 1'b1, got);
		fpshp_link_master_inst.edge_step(8'h00, 1'b1, got);
		fpshp_link_master_inst.stop(ack);
		check(8'(ack), 8'(LINK_NAK));
		check(8'(txq.size()), 8'h00);
		status_enable = 1'b0;
		repeat (12) @(negedge clock);
	endtask : t_link

	initial begin
		t_async();
		t_sync();
		t_link();
		summarize();
	end

	initial begin
		repeat (6000) @(posedge clock);
		num_errors++;
		summarize();
	end
endmodule : tb_fifo_parallel_serial_host_port

`default_nettype wire
